// ---- design/radio_fifo_packet_handler.sv ----
// radio data queues and packet handler
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
// Contract
// (R1) two separate 64-byte queues, one transmit, one receive
// (R2) host write to port 66h pushes the byte into the transmit queue
// (R3) host read of port 77h pops and returns a receive queue byte
// (R4) transmit queue falling to its threshold raises an event
// (R5) with no more transmit data, leave transmit after the frame-done event
// (R6) receive queue at its threshold pulls the interrupt pin low
// (R7) receive indication means at least threshold bytes are readable
// (R8) host reads the receive queue on the receive interrupt
// (R9) queue reset command clears transmit, receive, or both queues
// (R10) packet handling enables separately for transmit and receive
// (R11) preamble, sync, header, length and crc are each configurable
// (R12) receive flags a valid preamble when detected
// (R13) receive flags sync detected when the sync word matches
// (R14) receive flags a good packet when all enabled checks pass
// (R15) receive flags a crc error on mismatch when crc is enabled
// (R16) receive de-whitens and manchester-decodes when enabled
// (R17) receive compares the header byte and reports agreement
// (R18) receive stores data bytes into the receive queue in order
// (R19) transmit sends preamble then sync ahead of the payload
// (R20) transmit data field is taken from the transmit queue in order
// (R21) transmit appends a crc over the protected fields when enabled
// (R22) transmit whitens and manchester-encodes when enabled
// (R23) queues count 0 to 64; full writes and empty reads are ignored
module radio_fifo_packet_handler
  import radio_ph_pkg::*;
(
  input  logic       clock,
  input  logic       rst,
  input  bus_req_t   bus,
  output logic [7:0] rd_data,
  input  logic       tx_bit_req,
  output logic       tx_bit,
  output logic       tx_active,
  input  logic       rx_chip_valid,
  input  logic       rx_chip,
  output logic       interrupt_request_n,
  output logic       packet_good_flag,
  output logic       frame_done_event
);
  typedef struct packed {
    logic [63:0][7:0] txq;
    logic [63:0][7:0] rxq;
    logic [5:0]       txw, txr, rxw, rxr;
    logic [6:0]       txc, rxc;
    logic [7:0]       ctrl, mode, txthr, rxthr, prelen, synch, syncl, hdr, plen, stat, rdata;
    tx_state_t        ts;
    logic [2:0]       tf, tbit;
    logic [7:0]       tcnt, tsh;
    logic             thalf, tlast, tbitout, tdone;
    logic [15:0]      tcrc;
    logic [8:0]       tpn;
    rx_state_t        rs;
    logic [2:0]       rf, rbit;
    logic [7:0]       rcnt, rsh, rlen;
    logic             rhalf, rfirst, rprev, hdr_ok, crc_ok, good;
    logic [4:0]       run;
    logic [15:0]      rhist, rcrc;
    logic [8:0]       rpn;
  } st_t;

  localparam st_t ST_INIT = '{ts: TX_IDLE, rs: R_OFF, ctrl: CTRL_RST, txthr: TXTHR_RST,
                              rxthr: RXTHR_RST, prelen: PRELEN_RST, synch: SYNC_H_RST,
                              syncl: SYNC_L_RST, plen: LEN_RST, tpn: PN_INIT, rpn: PN_INIT,
                              tcrc: CRC_INIT, rcrc: CRC_INIT, hdr_ok: 1'b1, crc_ok: 1'b1,
                              default: '0};

  st_t        s_reg, s_next;
  logic       tx_push, tx_pop, rx_push, rx_pop, tx_go, frst_wr, stat_rd, tx_start;
  logic       tph, rph, wh_t, wh_r, mn_t, mn_r, tld, tchip, rx_bv, rx_b, rx_d;
  logic       rx_restart, rx_fstart, hok, cok;
  logic [5:0] tfen, rfen;
  logic [2:0] lf, nf;
  logic [7:0] lc, rb, ev, rx_head;
  logic [15:0] hist_n;
  logic [4:0] run_n;

  assign rx_head = s_reg.rxq[s_reg.rxr];

  always_comb begin
    s_next = s_reg;
    ev = '0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    tld = 1'b0;
    lf = F_NONE;
    lc = '0;
    nf = F_NONE;
    tchip = 1'b0;
    rx_bv = 1'b0;
    rx_b = 1'b0;
    rx_d = 1'b0;
    rb = '0;
    rx_restart = 1'b0;
    rx_fstart = 1'b0;
    hok = s_reg.hdr_ok;
    cok = s_reg.crc_ok;
    hist_n = s_reg.rhist;
    run_n = s_reg.run;
    tph = s_reg.ctrl[C_TXPH];
    rph = s_reg.ctrl[C_RXPH];
    wh_t = tph & s_reg.ctrl[C_WHITEN];
    wh_r = rph & s_reg.ctrl[C_WHITEN];
    mn_t = tph & s_reg.mode[M_MANCH];
    mn_r = rph & s_reg.mode[M_MANCH];
    tfen = {tph & s_reg.ctrl[C_CRC], 1'b1, tph & s_reg.ctrl[C_LEN], tph & s_reg.ctrl[C_HDR],
            tph & s_reg.ctrl[C_SYNC], tph & s_reg.ctrl[C_PRE]}; // R10 R11
    rfen = {rph & s_reg.ctrl[C_CRC], 1'b1, rph & s_reg.ctrl[C_LEN], rph & s_reg.ctrl[C_HDR],
            2'b00}; // R10 R11
    // register port
    tx_push = bus.wr && bus.addr == TXQ_PORT && s_reg.txc != QDEPTH; // R2 R23
    rx_pop = bus.rd && bus.addr == RXQ_PORT && s_reg.rxc != 7'h00; // R3 R23
    tx_go = bus.wr && bus.addr == MODE_ADDR && bus.wdata[M_TXGO];
    frst_wr = bus.wr && bus.addr == FRST_ADDR;
    stat_rd = bus.rd && bus.addr == STAT_ADDR;
    if (bus.wr) begin
      case (bus.addr)
        CTRL_ADDR:   s_next.ctrl = bus.wdata;
        MODE_ADDR:   s_next.mode = bus.wdata & MODE_MASK;
        TXTHR_ADDR:  s_next.txthr = bus.wdata;
        RXTHR_ADDR:  s_next.rxthr = bus.wdata;
        PRELEN_ADDR: s_next.prelen = bus.wdata;
        SYNCH_ADDR:  s_next.synch = bus.wdata;
        SYNCL_ADDR:  s_next.syncl = bus.wdata;
        HDR_ADDR:    s_next.hdr = bus.wdata;
        LEN_ADDR:    s_next.plen = bus.wdata;
        default: ;
      endcase
    end
    s_next.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        RXQ_PORT:    s_next.rdata = rx_pop ? rx_head : 8'h00; // R3
        CTRL_ADDR:   s_next.rdata = s_reg.ctrl;
        MODE_ADDR:   s_next.rdata = s_reg.mode;
        TXTHR_ADDR:  s_next.rdata = s_reg.txthr;
        RXTHR_ADDR:  s_next.rdata = s_reg.rxthr;
        PRELEN_ADDR: s_next.rdata = s_reg.prelen;
        SYNCH_ADDR:  s_next.rdata = s_reg.synch;
        SYNCL_ADDR:  s_next.rdata = s_reg.syncl;
        HDR_ADDR:    s_next.rdata = s_reg.hdr;
        LEN_ADDR:    s_next.rdata = s_reg.plen;
        STAT_ADDR:   s_next.rdata = s_reg.stat;
        TXCNT_ADDR:  s_next.rdata = {1'b0, s_reg.txc};
        RXCNT_ADDR:  s_next.rdata = {1'b0, s_reg.rxc};
        default:     s_next.rdata = 8'h00;
      endcase
    end
    // transmit framer
    tx_start = 1'b0;
    case (s_reg.ts)
      TX_IDLE: tx_start = tx_go && s_reg.txc != 7'h00;
      TX_SEND: begin
        if (tx_bit_req) begin
          tchip = s_reg.tsh[7] ^ (wh_t && s_reg.tf >= F_HDR && s_reg.tpn[0]); // R22
          if (mn_t && s_reg.thalf) begin
            s_next.tbitout = !s_reg.tlast; // R22
            s_next.thalf = 1'b0;
          end else begin
            s_next.tbitout = tchip;
            s_next.tlast = tchip;
            s_next.thalf = mn_t;
          end
          if (!mn_t || s_reg.thalf) begin
            if (wh_t && s_reg.tf >= F_HDR) s_next.tpn = pn_step(s_reg.tpn); // R22
            if (s_reg.tf >= F_HDR && s_reg.tf <= F_DATA) begin
              s_next.tcrc = crc_step(s_reg.tcrc, s_reg.tsh[7]); // R21
            end
            s_next.tsh = {s_reg.tsh[6:0], 1'b0};
            s_next.tbit = 3'(s_reg.tbit + 3'h1);
            if (s_reg.tbit == 3'h7) begin
              if (8'(s_reg.tcnt + 8'h01) == field_size(s_reg.tf, s_reg.prelen, s_reg.plen)) begin
                nf = field_from(3'(s_reg.tf + 3'h1), tfen); // R19 R21
                if (nf == F_NONE) begin
                  s_next.ts = TX_DONE;
                end else begin
                  tld = 1'b1;
                  lf = nf;
                end
              end else begin
                tld = 1'b1;
                lf = s_reg.tf;
                lc = 8'(s_reg.tcnt + 8'h01);
              end
            end
          end
        end
      end
      TX_DONE: begin
        ev[ST_DONE] = 1'b1;
        tx_start = s_reg.txc != 7'h00;
        s_next.ts = TX_IDLE; // R5
      end
      default: s_next.ts = TX_IDLE;
    endcase
    if (tx_start) begin
      tld = 1'b1;
      lf = field_from(F_PRE, tfen);
      s_next.ts = TX_SEND;
      s_next.tpn = PN_INIT;
      s_next.tcrc = CRC_INIT;
      s_next.thalf = 1'b0;
    end
    if (tld) begin
      s_next.tf = lf;
      s_next.tcnt = lc;
      s_next.tbit = 3'h0;
      case (lf)
        F_PRE:   s_next.tsh = PREAMBLE_BYTE; // R19
        F_SYNC:  s_next.tsh = (lc == 8'h00) ? s_reg.synch : s_reg.syncl; // R19
        F_HDR:   s_next.tsh = s_reg.hdr; // R11
        F_LEN:   s_next.tsh = s_reg.plen; // R11
        F_CRC:   s_next.tsh = (lc == 8'h00) ? s_next.tcrc[15:8] : s_next.tcrc[7:0]; // R21
        default: begin
          tx_pop = s_reg.txc != 7'h00; // R20 R23
          s_next.tsh = tx_pop ? s_reg.txq[s_reg.txr] : 8'h00; // R20
        end
      endcase
    end
    s_next.tdone = ev[ST_DONE];
    // receive deframer
    if (rx_chip_valid && s_reg.rs != R_OFF) begin
      if (mn_r && !s_reg.rhalf) begin
        s_next.rfirst = rx_chip;
        s_next.rhalf = 1'b1;
      end else begin
        s_next.rhalf = 1'b0;
        rx_bv = 1'b1;
        rx_b = mn_r ? s_reg.rfirst : rx_chip; // R16
      end
    end
    if (rx_bv) begin
      hist_n = {s_reg.rhist[14:0], rx_b};
      if (rx_b == s_reg.rprev) run_n = 5'h01;
      else run_n = (s_reg.run == RUN_MAX) ? RUN_MAX : 5'(s_reg.run + 5'h01);
      s_next.rhist = hist_n;
      s_next.run = run_n;
      s_next.rprev = rx_b;
      case (s_reg.rs)
        R_PRE: begin
          if (run_n >= PRE_DET_BITS) begin
            ev[ST_PRE] = 1'b1; // R12
            if (s_reg.ctrl[C_SYNC]) s_next.rs = R_SYNC;
            else rx_fstart = 1'b1;
          end
        end
        R_SYNC: begin
          if (hist_n == {s_reg.synch, s_reg.syncl}) begin
            ev[ST_SYNC] = 1'b1; // R13
            rx_fstart = 1'b1;
          end
        end
        R_FLD: begin
          rx_d = rx_b ^ (wh_r && s_reg.rf >= F_HDR && s_reg.rpn[0]); // R16
          if (wh_r && s_reg.rf >= F_HDR) s_next.rpn = pn_step(s_reg.rpn);
          if (s_reg.rf <= F_DATA) s_next.rcrc = crc_step(s_reg.rcrc, rx_d);
          rb = {s_reg.rsh[6:0], rx_d};
          s_next.rsh = rb;
          s_next.rbit = 3'(s_reg.rbit + 3'h1);
          if (s_reg.rbit == 3'h7) begin
            case (s_reg.rf)
              F_HDR:   hok = hok && rb == s_reg.hdr; // R17
              F_LEN:   s_next.rlen = rb;
              F_DATA:  rx_push = s_reg.rxc != QDEPTH; // R18 R23
              F_CRC:   cok = cok && rb == ((s_reg.rcnt == 8'h00) ? s_reg.rcrc[15:8]
                                                                  : s_reg.rcrc[7:0]); // R15
              default: ;
            endcase
            s_next.hdr_ok = hok;
            s_next.crc_ok = cok;
            if (!rph) begin
              s_next.rcnt = '0;
            end else if (8'(s_reg.rcnt + 8'h01) ==
                         field_size(s_reg.rf, s_reg.prelen, s_reg.rlen)) begin
              nf = field_from(3'(s_reg.rf + 3'h1), rfen);
              if (nf == F_NONE) begin
                ev[ST_GOOD] = hok && cok; // R14
                ev[ST_CRC] = !cok; // R15
                ev[ST_HDRX] = !hok; // R17
                rx_restart = 1'b1;
              end else begin
                s_next.rf = nf;
                s_next.rcnt = '0;
              end
            end else begin
              s_next.rcnt = 8'(s_reg.rcnt + 8'h01);
            end
          end
        end
        default: ;
      endcase
    end
    if (s_reg.rs == R_OFF && s_reg.mode[M_RXON]) rx_restart = 1'b1;
    if (rx_restart) begin
      s_next.run = '0;
      s_next.rhalf = 1'b0;
      if (rph && s_reg.ctrl[C_PRE]) s_next.rs = R_PRE;
      else if (rph && s_reg.ctrl[C_SYNC]) s_next.rs = R_SYNC;
      else rx_fstart = 1'b1;
    end
    if (rx_fstart) begin
      s_next.rs = R_FLD;
      s_next.rf = rph ? field_from(F_HDR, rfen) : F_DATA;
      s_next.rcnt = '0;
      s_next.rbit = '0;
      s_next.rpn = PN_INIT;
      s_next.rcrc = CRC_INIT;
      s_next.hdr_ok = 1'b1;
      s_next.crc_ok = 1'b1;
      s_next.rlen = s_reg.plen;
    end
    if (!s_reg.mode[M_RXON]) s_next.rs = R_OFF;
    s_next.good = ev[ST_GOOD];
    // queues
    if (tx_push) begin
      s_next.txq[s_reg.txw] = bus.wdata; // R2
      s_next.txw = 6'(s_reg.txw + 6'h01);
    end
    if (tx_pop) s_next.txr = 6'(s_reg.txr + 6'h01);
    s_next.txc = 7'(s_reg.txc + {6'h00, tx_push} - {6'h00, tx_pop}); // R1 R23
    if (rx_push) begin
      s_next.rxq[s_reg.rxw] = rb; // R18
      s_next.rxw = 6'(s_reg.rxw + 6'h01);
    end
    if (rx_pop) s_next.rxr = 6'(s_reg.rxr + 6'h01);
    s_next.rxc = 7'(s_reg.rxc + {6'h00, rx_push} - {6'h00, rx_pop}); // R1 R23
    if (frst_wr && bus.wdata[Q_TX]) begin
      s_next.txw = '0; // R9
      s_next.txr = '0;
      s_next.txc = '0;
    end
    if (frst_wr && bus.wdata[Q_RX]) begin
      s_next.rxw = '0; // R9
      s_next.rxr = '0;
      s_next.rxc = '0;
    end
    // threshold events judged on the settled count, so a same-cycle push and pop with the count at the threshold still raise one
    ev[ST_TXLOW] = tx_pop && {1'b0, s_next.txc} == s_reg.txthr; // R4
    ev[ST_RXTHR] = rx_push && {1'b0, s_next.rxc} == s_reg.rxthr; // R6 R7
    s_next.stat = (stat_rd ? 8'h00 : s_reg.stat) | ev;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) s_reg <= ST_INIT;
    else s_reg <= s_next;
  end

  assign rd_data = s_reg.rdata;
  assign tx_bit = s_reg.tbitout;
  assign tx_active = s_reg.ts == TX_SEND;
  assign packet_good_flag = s_reg.good;
  assign frame_done_event = s_reg.tdone;
  assign interrupt_request_n = !((s_reg.rxthr != 8'h00 && {1'b0, s_reg.rxc} >= s_reg.rxthr)
                                 || s_reg.stat[ST_TXLOW] || s_reg.stat[ST_DONE]); // R6 R7

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_queue_count_max: // R1
    assert property (s_reg.txc <= QDEPTH && s_reg.rxc <= QDEPTH) else $error("queue over 64");
  a_txq_push_count: // R2
    assert property (tx_push && !tx_pop |=> s_reg.txc == $past(s_reg.txc) + 7'h01)
      else $error("push not counted");
  a_rxq_pop_data: // R3
    assert property (rx_pop |=> rd_data == $past(rx_head)) else $error("wrong rx byte");
  a_full_write_drop: // R23
    assert property (bus.wr && bus.addr == TXQ_PORT && s_reg.txc == QDEPTH |=> $stable(s_reg.txw))
      else $error("full queue written");
  a_tx_low_flag: // R4
    assert property (tx_pop && !tx_push && !frst_wr
                     && 8'(s_reg.txc) == 8'(s_reg.txthr + 8'h01) |=> s_reg.stat[ST_TXLOW])
      else $error("low threshold missed");
  a_tx_auto_exit: // R5
    assert property (s_reg.ts == TX_DONE && s_reg.txc == 7'h00 |=> s_reg.ts == TX_IDLE
                     && frame_done_event ##1 !frame_done_event) else $error("tx did not exit");
  a_irq_rx_level: // R7
    assert property ($rose(s_reg.stat[ST_RXTHR]) |-> {1'b0, s_reg.rxc} >= $past(s_reg.rxthr))
      else $error("irq without data");
  a_irq_rx_cross: // R6
    assert property (rx_push && !rx_pop && !frst_wr
                     && 8'({1'b0, s_reg.rxc} + 8'h01) == s_reg.rxthr
                     |=> !interrupt_request_n) else $error("rx threshold irq missing");
  a_rx_push_order: // R18
    assert property (rx_push && !frst_wr |=> s_reg.rxw == $past(s_reg.rxw) + 6'h01)
      else $error("rx push lost");
  a_manch_pair: // R22
    assert property (s_reg.ts == TX_SEND && mn_t && tx_bit_req && s_reg.thalf
                     |=> tx_bit == !$past(s_reg.tlast)) else $error("manchester pair broken");
  a_sync_flag: // R13
    assert property (s_reg.rs == R_SYNC && rx_bv && hist_n == {s_reg.synch, s_reg.syncl}
                     |=> s_reg.stat[ST_SYNC] && s_reg.rs == R_FLD) else $error("sync missed");

  c_frame_sent: cover property (frame_done_event);
  c_packet_good: cover property (packet_good_flag);
  c_rx_irq: cover property (!interrupt_request_n && s_reg.rxc != 7'h00);
  c_tx_full: cover property (s_reg.txc == QDEPTH);
endmodule : radio_fifo_packet_handler

// ---- design/radio_ph_pkg.sv ----
// constants, types and helpers for the radio queue and packet handler
package radio_ph_pkg;
  localparam logic [7:0] TXQ_PORT    = 8'h66;
  localparam logic [7:0] RXQ_PORT    = 8'h77;
  localparam logic [7:0] CTRL_ADDR   = 8'h10;
  localparam logic [7:0] MODE_ADDR   = 8'h11;
  localparam logic [7:0] FRST_ADDR   = 8'h12;
  localparam logic [7:0] TXTHR_ADDR  = 8'h13;
  localparam logic [7:0] RXTHR_ADDR  = 8'h14;
  localparam logic [7:0] PRELEN_ADDR = 8'h15;
  localparam logic [7:0] SYNCH_ADDR  = 8'h16;
  localparam logic [7:0] SYNCL_ADDR  = 8'h17;
  localparam logic [7:0] HDR_ADDR    = 8'h18;
  localparam logic [7:0] LEN_ADDR    = 8'h19;
  localparam logic [7:0] STAT_ADDR   = 8'h1A;
  localparam logic [7:0] TXCNT_ADDR  = 8'h1B;
  localparam logic [7:0] RXCNT_ADDR  = 8'h1C;
  // ctrl bits
  localparam int C_TXPH = 0, C_RXPH = 1, C_PRE = 2, C_SYNC = 3;
  localparam int C_HDR = 4, C_LEN = 5, C_CRC = 6, C_WHITEN = 7;
  // mode bits and fifo reset bits
  localparam int M_MANCH = 0, M_TXGO = 1, M_RXON = 2;
  localparam logic [7:0] MODE_MASK = 8'h05;
  localparam int Q_TX = 0, Q_RX = 1;
  // status bits
  localparam int ST_TXLOW = 0, ST_DONE = 1, ST_RXTHR = 2, ST_PRE = 3;
  localparam int ST_SYNC = 4, ST_GOOD = 5, ST_CRC = 6, ST_HDRX = 7;
  // reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] TXTHR_RST  = 8'h00;
  localparam logic [7:0] RXTHR_RST  = 8'h20;
  localparam logic [7:0] PRELEN_RST = 8'h04;
  localparam logic [7:0] SYNC_H_RST = 8'h2D;
  localparam logic [7:0] SYNC_L_RST = 8'hD4;
  localparam logic [7:0] LEN_RST    = 8'h08;
  // queue and framing figures
  localparam logic [6:0]  QDEPTH        = 7'h40;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'hAA;
  localparam logic [4:0]  PRE_DET_BITS  = 5'h10;
  localparam logic [4:0]  RUN_MAX       = 5'h1F;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [8:0]  PN_INIT       = 9'h1FF;
  localparam logic [7:0]  ONE_BYTE      = 8'h01;
  localparam logic [7:0]  TWO_BYTES     = 8'h02;
  // field order
  localparam logic [2:0] F_PRE = 3'h0, F_SYNC = 3'h1, F_HDR = 3'h2, F_LEN = 3'h3;
  localparam logic [2:0] F_DATA = 3'h4, F_CRC = 3'h5, F_NONE = 3'h6;

  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SEND = 3'b010, TX_DONE = 3'b100} tx_state_t;
  typedef enum logic [3:0] {
    R_OFF = 4'b0001, R_PRE = 4'b0010, R_SYNC = 4'b0100, R_FLD = 4'b1000
  } rx_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[15] ^ b) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
  endfunction : crc_step

  function automatic logic [8:0] pn_step(input logic [8:0] p);
    pn_step = {p[0] ^ p[5], p[8:1]};
  endfunction : pn_step

  // first enabled field at or after from
  function automatic logic [2:0] field_from(input logic [2:0] from, input logic [5:0] en);
    field_from = F_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (i >= int'(from) && en[i]) field_from = 3'(i);
    end
  endfunction : field_from

  function automatic logic [7:0] field_size(input logic [2:0] f, input logic [7:0] pl,
                                            input logic [7:0] dl);
    case (f)
      F_PRE:   field_size = pl;
      F_DATA:  field_size = dl;
      F_SYNC,
      F_CRC:   field_size = TWO_BYTES;
      default: field_size = ONE_BYTE;
    endcase
  endfunction : field_size
endpackage : radio_ph_pkg

// ---- verif/radio_fifo_packet_handler_tb.sv ----
// self-checking bench for the radio queues and packet handler
`timescale 1ns/1ps
module radio_fifo_packet_handler_tb
  import radio_ph_pkg::*;
;
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
  logic       clock;
  logic       rst;
  bus_req_t   bus;
  logic [7:0] rd_data;
  logic       tx_bit_req;
  logic       tx_bit;
  logic       tx_active;
  logic       rx_chip_valid;
  logic       rx_chip;
  logic       interrupt_request_n;
  logic       packet_good_flag;
  logic       frame_done_event;
  logic       loop_en;
  logic [3:0] gap;
  logic [7:0] v;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         n_good;
  int         n_done;
  logic [7:0] ra [11] = '{CTRL_ADDR, RXTHR_ADDR, PRELEN_ADDR, SYNCH_ADDR, SYNCL_ADDR,
                          LEN_ADDR, TXCNT_ADDR, RXCNT_ADDR, RXQ_PORT, TXQ_PORT, 8'h00};
  logic [7:0] rv [11] = '{CTRL_RST, RXTHR_RST, PRELEN_RST, SYNC_H_RST, SYNC_L_RST,
                          LEN_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cc [3]  = '{8'h00, 8'h7F, 8'hFF};
  logic [7:0] mc [3]  = '{8'h04, 8'h04, 8'h05};
  logic [3:0] gc [3]  = '{4'h0, 4'h1, 4'h5};

  radio_fifo_packet_handler DUT (
    .clock               (clock),
    .rst                 (rst),
    .bus                 (bus),
    .rd_data             (rd_data),
    .tx_bit_req          (tx_bit_req),
    .tx_bit              (tx_bit),
    .tx_active           (tx_active),
    .rx_chip_valid       (rx_chip_valid),
    .rx_chip             (rx_chip),
    .interrupt_request_n (interrupt_request_n),
    .packet_good_flag    (packet_good_flag),
    .frame_done_event    (frame_done_event)
  );

  radio_modem_model MODEM (
    .clock         (clock),
    .rst           (rst),
    .tx_active     (tx_active),
    .tx_bit        (tx_bit),
    .loop_en       (loop_en),
    .gap           (gap),
    .tx_bit_req    (tx_bit_req),
    .rx_chip_valid (rx_chip_valid),
    .rx_chip       (rx_chip)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    if (packet_good_flag === 1'b1) n_good++;
    if (frame_done_event === 1'b1) n_done++;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 d = rd_data;
    @(posedge clock);
  endtask : rd

  task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK("read data", e, d)
  endtask : chkrd

  initial begin
    repeat (10000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end

  initial begin
    rst     = 1'b1;
    bus     = '0;
    loop_en = 1'b0;
    gap     = 4'h0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("irq_n", 1'b1, interrupt_request_n)
    @(posedge clock);
    for (int i = 0; i < 11; i++) chkrd(ra[i], rv[i]);
    for (int i = 0; i < 65; i++) wr(TXQ_PORT, 8'(i));
    chkrd(TXCNT_ADDR, 8'h40);
    wr(FRST_ADDR, 8'h01);
    chkrd(TXCNT_ADDR, 8'h00);
    // raw, all fields, all fields with whitening and manchester
    for (int k = 0; k < 3; k++) begin
      // receiver off first so the new framing starts from a fresh hunt
      wr(MODE_ADDR, 8'h00);
      wr(FRST_ADDR, 8'h03);
      wr(LEN_ADDR, 8'h04);
      wr(RXTHR_ADDR, 8'h04);
      wr(CTRL_ADDR, cc[k]);
      wr(MODE_ADDR, mc[k]);
      for (int i = 0; i < 4; i++) wr(TXQ_PORT, 8'hA0 + 8'(16 * i + k));
      rd(STAT_ADDR, v);
      gap     <= gc[k];
      loop_en <= 1'b1;
      n_good = 0;
      n_done = 0;
      wr(MODE_ADDR, mc[k] | 8'h02);
      for (int t = 0; t < 4000 && n_done == 0; t++) @(posedge clock);
      repeat (4) @(posedge clock);
      #1;
      `CHK("frame done", 1, n_done)
      `CHK("tx active", 1'b0, tx_active)
      `CHK("irq_n", 1'b0, interrupt_request_n)
      `CHK("packet good", (k == 0) ? 0 : 1, n_good)
      @(posedge clock);
      chkrd(RXCNT_ADDR, 8'h04);
      for (int i = 0; i < 4; i++) chkrd(RXQ_PORT, 8'hA0 + 8'(16 * i + k));
      chkrd(STAT_ADDR, (k == 0) ? 8'h07 : 8'h3F);
      `CHK("irq_n", 1'b1, interrupt_request_n)
    end
    chkrd(RXQ_PORT, 8'h00);
    complete_run();
  end
endmodule : radio_fifo_packet_handler_tb

// ---- verif/radio_modem_model.sv ----
// modem model: requests transmit chips and loops them back as received chips
`timescale 1ns/1ps
module radio_modem_model (
  input  logic       clock,
  input  logic       rst,
  input  logic       tx_active,
  input  logic       tx_bit,
  input  logic       loop_en,
  input  logic [3:0] gap,
  output logic       tx_bit_req,
  output logic       rx_chip_valid,
  output logic       rx_chip
);
  logic [3:0] wait_reg;
  logic       pend_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_reg      <= 4'h0;
      pend_reg      <= 1'b0;
      tx_bit_req    <= 1'b0;
      rx_chip_valid <= 1'b0;
      rx_chip       <= 1'b0;
    end else begin
      pend_reg      <= tx_bit_req;
      rx_chip_valid <= pend_reg && loop_en;
      // between chips the line keeps changing, never a stale value
      rx_chip       <= (pend_reg && loop_en) ? tx_bit : ~rx_chip;
      tx_bit_req    <= 1'b0;
      if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else if (tx_active && !tx_bit_req) begin
        tx_bit_req <= 1'b1;
        wait_reg   <= gap;
      end
    end
  end
endmodule : radio_modem_model
